// ===== hdl/rtc_pkg.sv
// Constants shared by the watch and calendar clock block
package rtc_pkg;
    // Crystal and tick rates
    localparam int unsigned XTAL_HZ = 32768;
    localparam int unsigned TICK_HZ = 1;
    localparam int unsigned PRESCALE_DIV = XTAL_HZ / TICK_HZ;
    localparam int unsigned SWATCH_W = 16;

    // Counter widths and last values before wrap
    localparam int unsigned SEC_W = 6;
    localparam int unsigned MIN_W = 6;
    localparam int unsigned HOUR_W = 5;
    localparam int unsigned DAY_W = 15;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [5:0] MIN_LAST = 6'h3B;
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [14:0] DAY_LAST = 15'h7FFF;

    // Register byte offsets
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFF_TIME = 5'h00;
    localparam logic [4:0] OFF_DAY = 5'h04;
    localparam logic [4:0] OFF_ALM_TIME = 5'h08;
    localparam logic [4:0] OFF_ALM_DAY = 5'h0C;
    localparam logic [4:0] OFF_CTRL = 5'h10;
    localparam logic [4:0] OFF_STATUS = 5'h14;
    localparam logic [4:0] OFF_SWATCH = 5'h18;

    // Field positions in the time-of-day words
    localparam int unsigned TIME_SEC_LSB = 0;
    localparam int unsigned TIME_MIN_LSB = 8;
    localparam int unsigned TIME_HOUR_LSB = 16;

    // Event bits, shared by control enables and status flags
    localparam int unsigned EV_SEC = 0;
    localparam int unsigned EV_MIN = 1;
    localparam int unsigned EV_HOUR = 2;
    localparam int unsigned EV_DAY = 3;
    localparam int unsigned EV_ALARM = 4;
    localparam int unsigned EV_SWATCH = 5;
    localparam int unsigned N_EV = 6;
    localparam int unsigned CTRL_FORM_BIT = 8;
    localparam int unsigned STAT_RUN_BIT = 8;

    // Values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ALM_RST = 32'h0000_0000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/rtc_sticky_flags.sv
// Sticky event flags, set by hardware and cleared by writing one
`timescale 1ns/100ps
module rtc_sticky_flags #(
    parameter int N = rtc_pkg::N_EV
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Events and clear strobes
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    // Flags
    output logic [N-1:0] flags
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            logic flag_q;
            // Set wins so an event in the clearing cycle is kept
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flag_q <= 1'b0;
                end else if (ce) begin
                    if (set[i]) begin
                        flag_q <= 1'b1;
                    end else if (clr[i]) begin
                        flag_q <= 1'b0;
                    end
                end
            end
            assign flags[i] = flag_q;
        end
    endgenerate
endmodule // rtc_sticky_flags

// ===== hdl/rtc_prescaler.sv
// Crystal pin sampler and divider to the one-second tick
`timescale 1ns/100ps
module rtc_prescaler #(
    parameter int unsigned DIV = rtc_pkg::PRESCALE_DIV
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Crystal clock pin
    input wire logic xtal_clk,
    // One-cycle tick
    output logic tick
);
    localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic [CW-1:0] cnt_q;
    logic rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            s1_q <= xtal_clk;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A level counts only once two sampled stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_q <= 1'b0;
        end else if (ce && (s2_q == s3_q)) begin
            lvl_q <= s3_q;
        end
    end

    assign rise = (s2_q == s3_q) && s3_q && !lvl_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (rise) begin
                if (cnt_q == LAST) begin
                    cnt_q <= '0;
                    tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
endmodule // rtc_prescaler

// ===== hdl/rtc_top.sv
// Watch and calendar clock with stopwatch, alarm and AXI4-Lite registers
`timescale 1ns/100ps
module rtc_top #(
    parameter int unsigned PRESCALE = rtc_pkg::PRESCALE_DIV,
    parameter int unsigned SW_W = rtc_pkg::SWATCH_W
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Crystal clock pin
    input wire logic xtal_clk,
    // AXI4-Lite write address
    input wire logic [rtc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [rtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt request
    output logic irq
);
    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Pack hour, minute, second into the time-of-day layout
    function automatic logic [31:0] pack_time(input logic [4:0] h,
                                              input logic [5:0] m,
                                              input logic [5:0] s);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[rtc_pkg::TIME_HOUR_LSB +: rtc_pkg::HOUR_W] = h;
        r[rtc_pkg::TIME_MIN_LSB +: rtc_pkg::MIN_W] = m;
        r[rtc_pkg::TIME_SEC_LSB +: rtc_pkg::SEC_W] = s;
        return r;
    endfunction

    logic tick;
    logic tick_d_q;

    logic [5:0] sec_q;
    logic [5:0] min_q;
    logic [4:0] hour_q;
    logic [14:0] day_q;
    logic [31:0] alm_time_q;
    logic [14:0] alm_day_q;
    logic [31:0] ctrl_q;
    logic [SW_W-1:0] sw_q;
    logic sw_run_q;

    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic alarm_match;
    logic sw_under;

    logic [rtc_pkg::N_EV-1:0] ev_set;
    logic [rtc_pkg::N_EV-1:0] ev_clr;
    logic [rtc_pkg::N_EV-1:0] flags;

    logic aw_have_q;
    logic w_have_q;
    logic [rtc_pkg::ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic wr_hit;
    logic [31:0] wr_time;
    logic [31:0] wr_day;
    logic [31:0] wr_sw;

    logic rd_hit;
    logic [31:0] rd_word;

    rtc_prescaler #(
        .DIV(PRESCALE)
    ) u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .xtal_clk(xtal_clk),
        .tick(tick)
    );

    // Write channel: address and data are taken in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_comb begin
        case (awaddr_q)
            rtc_pkg::OFF_TIME, rtc_pkg::OFF_DAY, rtc_pkg::OFF_ALM_TIME,
            rtc_pkg::OFF_ALM_DAY, rtc_pkg::OFF_CTRL, rtc_pkg::OFF_STATUS,
            rtc_pkg::OFF_SWATCH: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rtc_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? rtc_pkg::RESP_OKAY
                                      : rtc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign wr_time = merge(pack_time(hour_q, min_q, sec_q), wdata_q, wstrb_q);
    assign wr_day = merge({17'h0_0000, day_q}, wdata_q, wstrb_q);
    assign wr_sw = merge({{(32-SW_W){1'b0}}, sw_q}, wdata_q, wstrb_q);

    // Timekeeping chain; a software write beats a tick in the same cycle
    assign sec_wrap = sec_q >= rtc_pkg::SEC_LAST;
    assign min_wrap = sec_wrap && (min_q >= rtc_pkg::MIN_LAST);
    assign hour_wrap = min_wrap && (hour_q >= rtc_pkg::HOUR_LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_q <= '0;
            min_q <= '0;
            hour_q <= '0;
        end else if (ce) begin
            if (wr_go && awaddr_q == rtc_pkg::OFF_TIME) begin
                sec_q <= wr_time[rtc_pkg::TIME_SEC_LSB +: rtc_pkg::SEC_W];
                min_q <= wr_time[rtc_pkg::TIME_MIN_LSB +: rtc_pkg::MIN_W];
                hour_q <= wr_time[rtc_pkg::TIME_HOUR_LSB +: rtc_pkg::HOUR_W];
            end else if (tick) begin
                sec_q <= sec_wrap ? '0 : sec_q + 1'b1;
                if (sec_wrap) begin
                    min_q <= min_wrap ? '0 : min_q + 1'b1;
                end
                if (min_wrap) begin
                    hour_q <= hour_wrap ? '0 : hour_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            day_q <= '0;
        end else if (ce) begin
            if (wr_go && awaddr_q == rtc_pkg::OFF_DAY) begin
                day_q <= wr_day[rtc_pkg::DAY_W-1:0];
            end else if (tick && hour_wrap) begin
                // A compare with DAY_LAST, the 15-bit maximum, returns the day to zero
                day_q <= (day_q == rtc_pkg::DAY_LAST) ? '0 : day_q + 1'b1;
            end
        end
    end

    // Alarm setting and control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alm_time_q <= rtc_pkg::ALM_RST;
            alm_day_q <= '0;
            ctrl_q <= rtc_pkg::CTRL_RST;
        end else if (ce && wr_go) begin
            case (awaddr_q)
                rtc_pkg::OFF_ALM_TIME: alm_time_q <= merge(alm_time_q,
                                                           wdata_q, wstrb_q);
                rtc_pkg::OFF_ALM_DAY: alm_day_q <= wr_day[rtc_pkg::DAY_W-1:0];
                rtc_pkg::OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
                default: ;
            endcase
        end
    end

    // Compare one cycle after the tick so the new counter values are seen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_d_q <= 1'b0;
        end else if (ce) begin
            tick_d_q <= tick;
        end
    end

    assign alarm_match = tick_d_q
        && (pack_time(hour_q, min_q, sec_q) == pack_time(
               alm_time_q[rtc_pkg::TIME_HOUR_LSB +: rtc_pkg::HOUR_W],
               alm_time_q[rtc_pkg::TIME_MIN_LSB +: rtc_pkg::MIN_W],
               alm_time_q[rtc_pkg::TIME_SEC_LSB +: rtc_pkg::SEC_W]))
        && (!ctrl_q[rtc_pkg::CTRL_FORM_BIT] || day_q == alm_day_q);

    // Stopwatch: a load starts it, underflow from zero stops it
    assign sw_under = tick && sw_run_q && (sw_q == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_q <= '0;
            sw_run_q <= 1'b0;
        end else if (ce) begin
            if (wr_go && awaddr_q == rtc_pkg::OFF_SWATCH) begin
                sw_q <= wr_sw[SW_W-1:0];
                sw_run_q <= 1'b1;
            end else if (sw_under) begin
                sw_run_q <= 1'b0;
            end else if (tick && sw_run_q) begin
                sw_q <= sw_q - 1'b1;
            end
        end
    end

    // Events latch regardless of their enables
    always_comb begin
        ev_set = '0;
        ev_set[rtc_pkg::EV_SEC] = tick;
        ev_set[rtc_pkg::EV_MIN] = tick && sec_wrap;
        ev_set[rtc_pkg::EV_HOUR] = tick && min_wrap;
        ev_set[rtc_pkg::EV_DAY] = tick && hour_wrap;
        ev_set[rtc_pkg::EV_ALARM] = alarm_match;
        ev_set[rtc_pkg::EV_SWATCH] = sw_under;
        ev_clr = '0;
        if (wr_go && awaddr_q == rtc_pkg::OFF_STATUS && wstrb_q[0]) begin
            ev_clr = wdata_q[rtc_pkg::N_EV-1:0];
        end
    end

    rtc_sticky_flags #(
        .N(rtc_pkg::N_EV)
    ) u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .set(ev_set),
        .clr(ev_clr),
        .flags(flags)
    );

    // Only enabled flags reach the request line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(flags & ctrl_q[rtc_pkg::N_EV-1:0]);
        end
    end

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            rtc_pkg::OFF_TIME: rd_word = pack_time(hour_q, min_q, sec_q);
            rtc_pkg::OFF_DAY: rd_word = {17'h0_0000, day_q};
            rtc_pkg::OFF_ALM_TIME: rd_word = pack_time(
                alm_time_q[rtc_pkg::TIME_HOUR_LSB +: rtc_pkg::HOUR_W],
                alm_time_q[rtc_pkg::TIME_MIN_LSB +: rtc_pkg::MIN_W],
                alm_time_q[rtc_pkg::TIME_SEC_LSB +: rtc_pkg::SEC_W]);
            rtc_pkg::OFF_ALM_DAY: rd_word = {17'h0_0000, alm_day_q};
            rtc_pkg::OFF_CTRL: begin
                rd_word[rtc_pkg::N_EV-1:0] = ctrl_q[rtc_pkg::N_EV-1:0];
                rd_word[rtc_pkg::CTRL_FORM_BIT] = ctrl_q[rtc_pkg::CTRL_FORM_BIT];
            end
            rtc_pkg::OFF_STATUS: begin
                rd_word[rtc_pkg::N_EV-1:0] = flags;
                rd_word[rtc_pkg::STAT_RUN_BIT] = sw_run_q;
            end
            rtc_pkg::OFF_SWATCH: rd_word = {{(32-SW_W){1'b0}}, sw_q};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rtc_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? rtc_pkg::RESP_OKAY
                                      : rtc_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // rtc_top

// ===== sim/rtc_top_asserts.sv
// Bus handshake checks on the clock block register port
`timescale 1ns/100ps
module rtc_top_asserts (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [rtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic rd_take;
    logic wr_take;
    assign rd_take = s_axi_arvalid && s_axi_arready && ce;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                     s_axi_wready && ce;

    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped early");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while data pending");
    a_aw_blocked: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write open while response pending");
    a_rd_latency: assert property (rd_take |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_latency: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready && ce
        |=> !s_axi_bvalid)
        else $error("write response not released");
    a_unmapped_rd: assert property (rd_take && s_axi_araddr[4:2] == 3'h7
        |=> s_axi_rresp == rtc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_rd: assert property (rd_take && s_axi_araddr[4:2] != 3'h7
        && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rresp == rtc_pkg::RESP_OKAY)
        else $error("mapped read refused");
endmodule // rtc_top_asserts

// ===== sim/tb.sv
// Self-checking bench for the watch and calendar clock block
`timescale 1ns/100ps
module tb;
    localparam int PS = 4;
    localparam int HALF = 4;
    localparam int TICK = PS * HALF * 2;
    localparam logic [1:0] OK = rtc_pkg::RESP_OKAY;
    localparam logic [1:0] SE = rtc_pkg::RESP_SLVERR;
    localparam logic [4:0] TM = rtc_pkg::OFF_TIME;
    localparam logic [4:0] ST = rtc_pkg::OFF_STATUS;
    localparam logic [4:0] CT = rtc_pkg::OFF_CTRL;
    localparam logic [4:0] DY = rtc_pkg::OFF_DAY;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic xtal_clk = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int xc = 0;
    int t0;

    always #25 aclk = ~aclk;

    // Crystal kept slow so each level spans several samples
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        xc <= (xc == HALF - 1) ? 0 : xc + 1;
        if (xc == HALF - 1) begin
            xtal_clk <= ~xtal_clk;
        end
    end

    rtc_top #(.PRESCALE(PS), .SW_W(16)) i_dut (.aclk(aclk),
        .aresetn(aresetn), .ce(ce), .xtal_clk(xtal_clk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

    task automatic conclude();
        $display("fails %0d checks %0d", fails, check_count);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
    endtask

    task automatic rdr(input logic [4:0] a, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        rd = rdata;
        chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
    endtask

    // Polls a register field; bounded so a dead counter cannot hang
    task automatic poll(input logic [4:0] a, input logic [31:0] m,
                        input logic [31:0] v);
        int n;
        n = 0;
        do begin
            rdr(a, OK);
            n++;
        end while ((rd & m) !== v && n < 300);
        chk(rd & m, v);
    endtask

    task automatic wirq(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (irq !== v && n < 400);
        chk({31'h0, irq}, {31'h0, v});
    endtask

    task automatic t_reset();
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            rdr(5'(i * 4), OK);
            chk(rd, 32'h0);
        end
        rdr(5'h1C, SE);
        chk(rd, 32'h0);
        wr(5'h1C, 32'hFFFF_FFFF, SE);
    endtask

    task automatic t_prescale();
        wr(CT, 32'h1, OK);
        wr(ST, 32'h3F, OK);
        wirq(1'b0);
        wirq(1'b1);
        t0 = cyc;
        wr(ST, 32'h1, OK);
        wirq(1'b0);
        wirq(1'b1);
        chk(32'(cyc - t0), 32'(TICK));
    endtask

    task automatic t_rollover();
        wr(CT, 32'hF, OK);
        wr(DY, 32'h7FFF, OK);
        wr(TM, 32'h0017_3B3A, OK);
        wr(ST, 32'h3F, OK);
        poll(TM, 32'h001F_0000, 32'h0);
        chk(rd & 32'h001F_3F00, 32'h0);
        rdr(DY, OK);
        chk(rd, 32'h0);
        rdr(ST, OK);
        chk(rd & 32'hF, 32'hF);
        chk({31'h0, irq}, 32'h1);
        wr(ST, 32'hE, OK);
        rdr(ST, OK);
        chk(rd & 32'hE, 32'h0);
    endtask

    task automatic t_alarm();
        wr(CT, 32'h10, OK);
        wr(DY, 32'h3, OK);
        wr(rtc_pkg::OFF_ALM_TIME, 32'h2, OK);
        wr(rtc_pkg::OFF_ALM_DAY, 32'h5, OK);
        wr(TM, 32'h0, OK);
        wr(ST, 32'h3F, OK);
        poll(ST, 32'h10, 32'h10);
        rdr(TM, OK);
        chk(rd & 32'h3F, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(CT, 32'h110, OK);
        wr(TM, 32'h0, OK);
        wr(ST, 32'h3F, OK);
        poll(TM, 32'h3F, 32'h4);
        rdr(ST, OK);
        chk(rd & 32'h10, 32'h0);
        wr(DY, 32'h5, OK);
        wr(TM, 32'h0, OK);
        wr(ST, 32'h3F, OK);
        poll(ST, 32'h10, 32'h10);
        rdr(TM, OK);
        chk(rd & 32'h3F, 32'h2);
    endtask

    task automatic t_swatch();
        wr(CT, 32'h0, OK);
        wr(ST, 32'h3F, OK);
        t0 = cyc;
        wr(rtc_pkg::OFF_SWATCH, 32'h3, OK);
        rdr(ST, OK);
        chk(rd & 32'h100, 32'h100);
        poll(ST, 32'h20, 32'h20);
        chk(32'((cyc - t0) > 3 * TICK && (cyc - t0) < 4 * TICK + 40), 1);
        rdr(rtc_pkg::OFF_SWATCH, OK);
        chk(rd, 32'h0);
        rdr(ST, OK);
        chk(rd & 32'h120, 32'h20);
        chk({31'h0, irq}, 32'h0);
        wr(CT, 32'h20, OK);
        wirq(1'b1);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        conclude();
    end

    // Frozen clock enable must stop the prescaler and the counters
    task automatic t_freeze();
        logic [31:0] t1;
        rdr(TM, OK);
        t1 = rd;
        @(posedge aclk);
        ce <= 1'b0;
        repeat (3 * TICK) @(posedge aclk);
        ce <= 1'b1;
        rdr(TM, OK);
        chk(32'(((rd - t1) & 32'h3F) <= 32'h1), 32'h1);
    endtask

    initial begin
        // Three edges clear the crystal sampler as well
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_prescale();
        t_rollover();
        t_alarm();
        t_swatch();
        t_freeze();
        conclude();
    end
endmodule // tb

bind rtc_top rtc_top_asserts i_chk (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
